// file: include/osfc_pkg.sv
// Package for the optical sensor frame control register block
package osfc_pkg;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [6:0] ADDR_DATA_OUT_LO = 7'h0c;
  localparam logic [6:0] ADDR_DATA_OUT_HI = 7'h0d;
  localparam logic [6:0] ADDR_SHUTTER_LO = 7'h0e;
  localparam logic [6:0] ADDR_SHUTTER_HI = 7'h0f;
  localparam logic [6:0] ADDR_FRAME_LEN_LO = 7'h10;
  localparam logic [6:0] ADDR_FRAME_LEN_HI = 7'h11;
  localparam logic [6:0] ADDR_MOVE_ZERO = 7'h12;
  localparam logic [6:0] ADDR_SNAPSHOT = 7'h13;
  localparam logic [6:0] ADDR_PRAM_CMD = 7'h14;
  localparam logic [6:0] ADDR_SEC_CONFIG = 7'h16;
  localparam logic [6:0] ADDR_PIXEL_BURST = 7'h40;
  localparam logic [6:0] ADDR_PRAM_FILL = 7'h60;
  // ----------------------------------------
  // Command codes, field positions, resets
  // ----------------------------------------
  localparam logic [7:0] SNAPSHOT_GO = 8'h83;
  localparam logic [7:0] PRAM_ARM = 8'h1d;
  localparam logic [7:0] PRAM_OPEN = 8'h18;
  localparam logic [7:0] PRAM_CRC = 8'ha1;
  localparam logic [7:0] SEC_CONFIG_RST = 8'h34;
  localparam int SEC_CFG_LASER_OFF_BIT = 1;
  localparam logic [15:0] SHUTTER_RST = 16'h0085;
  localparam logic [15:0] CRC_SEED = 16'hffff;
  localparam int EXPO_STEP_SHIFT = 4;
  localparam int PIXEL_COUNT = 1536;
  localparam int BOUND_SETTLE_FRAMES = 2;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_HZ = 20_000_000;
  localparam int CRC_WAIT_MS = 7;
  localparam int CRC_WAIT_CYC = CRC_WAIT_MS * (CLK_HZ / 1000);
  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef struct packed {
    logic [15:0] frame_max;
    logic [15:0] frame_min;
    logic [15:0] shutter_max;
  } osfc_bounds_t;
  typedef enum logic [1:0] {
    OSFC_SPI_ADDR,
    OSFC_SPI_DATA,
    OSFC_SPI_DONE
  } osfc_spi_t;
  typedef enum logic [2:0] {
    OSFC_RAM_IDLE,
    OSFC_RAM_CAPTURE,
    OSFC_RAM_READY,
    OSFC_RAM_CRC,
    OSFC_RAM_CRC_WAIT
  } osfc_ram_t;
endpackage : osfc_pkg

// file: hw/osfc_fifo.sv
// Pixel FIFO between the sensor array and the capture writer
module osfc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;

  // Full and empty straight from the fill count
  assign in_ready = cnt_q < (AW+1)'(DEPTH);
  assign out_valid = cnt_q != '0;
  assign out_data = mem[rd_q];

  // Storage has no reset, only pointers and count do
  always_ff @(posedge clk)
  begin
    if (ce && push)
      mem[wr_q] <= in_data;
  end

  // Pointer and count update
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end
    else if (ce)
    begin
      if (push)
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      if (pop)
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : osfc_fifo

// file: hw/osfc_regs.sv
// Frame, exposure and pixel capture control behind the serial register port
// Functional notes
// RL1: Host reads exposure high byte then low byte back to back.
// RL2: Exposure checked every frame, adjusted when brightness leaves normal range.
// RL3: Each automatic step moves exposure by one sixteenth of its value.
// RL4: With auto gain off, exposure equals the programmed upper bound.
// RL5: Automatic exposure never exceeds the exposure upper bound.
// RL6: Offsets 0x10/0x11 read current 16-bit frame period in clocks.
// RL7: Host reads frame period high byte before low byte.
// RL8: Locked frame rate runs frames exactly the frame upper bound long.
// RL9: Frame counts map to rates by clock divided by count.
// RL10: Any write to 0x12 zeroes motion deltas and accumulators only.
// RL11: Writing 0x83 to 0x13 captures 1536 pixels into program RAM.
// RL12: Any write to 0x13 halts tracking until reset, firmware lost.
// RL13: Each read of 0x13 returns next pixel and advances the pointer.
// RL14: Single and burst pixel reads share one pointer.
// RL15: Pixel reads before capture completes return zero.
// RL16: Capture register keeps no written byte; reads zero or pixels.
// RL17: Host writes 0x1D, waits a frame, writes 0x18 before firmware download.
// RL18: Writing 0xA1 runs program RAM CRC; result after 7 ms plus frame.
// RL19: CRC test suspends tracking; host stays off the port meanwhile.
// RL20: Config register 0x16 resets to 0x34; host keeps bit 2 one.
// RL21: Config bit 1 forces active-low laser enable high.
// RL22: Auto gain off holds exposure at programmed upper bound.
// RL23: Locked frame rate bit takes frame length from upper bound.
// RL24: New bounds take effect after two complete frames; code applies them at the second frame end after load.
// RL25: Reading a high byte latches its low byte for the next read; code latches only shutter and frame period, not data out.
module osfc_regs #(
  parameter int CRC_WAIT = osfc_pkg::CRC_WAIT_CYC,
  parameter int FIFO_DEPTH = 16,
  parameter logic [7:0] BRIGHT_HIGH = 8'hc0,
  parameter logic [7:0] BRIGHT_LOW = 8'h40
) (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Serial register port pins
  input wire logic sclk,
  input wire logic mosi,
  input wire logic ncs_n,
  output logic miso,
  output logic miso_oe,
  // Extended configuration and bound values from the wider register set
  input wire logic auto_gain_off,
  input wire logic locked_frame_rate,
  input wire osfc_pkg::osfc_bounds_t bounds,
  input wire logic bounds_load,
  output logic bounds_busy,
  // Pixel array statistics and stream
  input wire logic [7:0] pix_avg,
  input wire logic [7:0] pix_max,
  input wire logic pix_valid,
  output logic pix_ready,
  input wire logic [7:0] pix_data,
  // Tracking, motion and laser
  output logic frame_start,
  output logic tracking_on,
  output logic motion_zero,
  output logic laser_enable_n
);
  localparam int PA = $clog2(osfc_pkg::PIXEL_COUNT);
  localparam logic [PA-1:0] PIX_LAST = PA'(osfc_pkg::PIXEL_COUNT - 1);
  localparam int WA = $clog2(CRC_WAIT + 1);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [2:0] sclk_s_q;
  logic [1:0] mosi_s_q;
  logic [1:0] ncs_s_q;
  // Third sclk stage only feeds the edge detector, never the first stage
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sclk_s_q <= 3'h7;
      mosi_s_q <= 2'h0;
      ncs_s_q <= 2'h3;
    end
    else if (ce)
    begin
      sclk_s_q <= {sclk_s_q[1:0], sclk};
      mosi_s_q <= {mosi_s_q[0], mosi};
      ncs_s_q <= {ncs_s_q[0], ncs_n};
    end
  end
  wire sel = ~ncs_s_q[1];
  wire sclk_rise = sel & sclk_s_q[1] & ~sclk_s_q[2];
  wire sclk_fall = sel & ~sclk_s_q[1] & sclk_s_q[2];

  // ----------------------------------------
  // Serial shifter: address byte (bit 7 = write), then one data byte
  // ----------------------------------------
  osfc_pkg::osfc_spi_t spi_q;
  logic [2:0] bit_q;
  logic [7:0] sh_in_q;
  logic [7:0] sh_out_q;
  logic [7:0] addr_q;
  wire [7:0] sh_next = {sh_in_q[6:0], mosi_s_q[1]};
  wire byte_done = sclk_rise & (bit_q == 3'h7);
  wire addr_done = byte_done & (spi_q == osfc_pkg::OSFC_SPI_ADDR);
  wire rd_strobe = addr_done & ~sh_next[7];
  wire wr_strobe = byte_done & (spi_q == osfc_pkg::OSFC_SPI_DATA) & addr_q[7];
  wire [6:0] acc_addr = rd_strobe ? sh_next[6:0] : addr_q[6:0];
  wire [7:0] wr_data = sh_next;
  logic [7:0] rd_data;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      spi_q <= osfc_pkg::OSFC_SPI_ADDR;
      bit_q <= 3'h0;
      sh_in_q <= 8'h00;
      sh_out_q <= 8'h00;
      addr_q <= 8'h00;
    end
    else if (ce)
    begin
      if (!sel)
      begin
        spi_q <= osfc_pkg::OSFC_SPI_ADDR;
        bit_q <= 3'h0;
      end
      else if (sclk_rise)
      begin
        bit_q <= bit_q + 3'h1;
        sh_in_q <= sh_next;
        if (bit_q == 3'h7)
        begin
          case (spi_q)
            osfc_pkg::OSFC_SPI_ADDR: spi_q <= osfc_pkg::OSFC_SPI_DATA;
            osfc_pkg::OSFC_SPI_DATA: spi_q <= osfc_pkg::OSFC_SPI_DONE;
            default: spi_q <= osfc_pkg::OSFC_SPI_DONE;
          endcase
        end
        if (addr_done)
          addr_q <= sh_next;
        if (rd_strobe)
          sh_out_q <= rd_data;
      end
      else if (sclk_fall && spi_q == osfc_pkg::OSFC_SPI_DATA && bit_q != 3'h0)
        sh_out_q <= {sh_out_q[6:0], 1'b0};
    end
  end
  // Read data leaves MSB first; driven only while selected
  assign miso = sh_out_q[7];
  assign miso_oe = sel & (spi_q == osfc_pkg::OSFC_SPI_DATA) & ~addr_q[7];

  // Address decode shared by reads and writes
  function automatic logic hit(input logic [6:0] a, input logic [6:0] reg_addr);
    hit = (a == reg_addr);
  endfunction : hit
  wire pix_rd = rd_strobe & (hit(acc_addr, osfc_pkg::ADDR_SNAPSHOT)
                             | hit(acc_addr, osfc_pkg::ADDR_PIXEL_BURST));

  // ----------------------------------------
  // Configuration, laser override, motion clear
  // ----------------------------------------
  logic [7:0] cfg_q;
  logic halted_q;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cfg_q <= osfc_pkg::SEC_CONFIG_RST;
    // RL20: config write and reset value
    else if (ce && wr_strobe && hit(acc_addr, osfc_pkg::ADDR_SEC_CONFIG))
      cfg_q <= wr_data;
  end
  // RL10: any data clears motion
  assign motion_zero = ce & wr_strobe & hit(acc_addr, osfc_pkg::ADDR_MOVE_ZERO);
  // RL21: forced laser off
  assign laser_enable_n = cfg_q[osfc_pkg::SEC_CFG_LASER_OFF_BIT] | ~tracking_on;

  // ----------------------------------------
  // Bound staging: new bounds wait two frame ends, the frame in progress plus one whole frame
  // ----------------------------------------
  osfc_pkg::osfc_bounds_t act_q;
  osfc_pkg::osfc_bounds_t pend_q;
  logic [1:0] settle_q;
  logic frame_end;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      act_q <= '0;
      pend_q <= '0;
      settle_q <= 2'h0;
    end
    else if (ce)
    begin
      // RL24: two frame delay
      if (bounds_load)
      begin
        pend_q <= bounds;
        settle_q <= 2'(osfc_pkg::BOUND_SETTLE_FRAMES);
      end
      else if (frame_end && settle_q != 2'h0)
      begin
        settle_q <= settle_q - 2'h1;
        if (settle_q == 2'h1)
          act_q <= pend_q;
      end
    end
  end
  assign bounds_busy = settle_q != 2'h0;

  // ----------------------------------------
  // Frame timer
  // ----------------------------------------
  logic [15:0] frame_cnt_q;
  logic [15:0] period_q;
  logic [15:0] shutter_q;
  wire [16:0] auto_sum = {1'b0, act_q.frame_min} + {1'b0, shutter_q};
  // RL23: locked rate uses the upper bound
  // RL8: exact manual length
  wire [15:0] period_d = locked_frame_rate ? act_q.frame_max
                       : (auto_sum > {1'b0, act_q.frame_max}) ? act_q.frame_max
                       : auto_sum[15:0];
  // A period of zero (bounds not yet loaded) would stall; keep a floor of one
  wire [15:0] period_use = (period_q == 16'h0) ? 16'h1 : period_q;
  assign frame_end = frame_cnt_q >= period_use - 16'h1;
  assign frame_start = ce & frame_end;
  // RL6: frame period is the live count length
  // RL9: rate is clock over this count
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      frame_cnt_q <= 16'h0;
      period_q <= 16'h0;
    end
    else if (ce)
    begin
      frame_cnt_q <= frame_end ? 16'h0 : frame_cnt_q + 16'h1;
      if (frame_end)
        period_q <= period_d;
    end
  end

  // ----------------------------------------
  // Exposure control
  // ----------------------------------------
  wire [15:0] step = shutter_q >> osfc_pkg::EXPO_STEP_SHIFT;
  wire too_bright = (pix_avg > BRIGHT_HIGH) | (pix_max == 8'hff);
  wire too_dark = pix_avg < BRIGHT_LOW;
  wire [16:0] up_sum = {1'b0, shutter_q} + {1'b0, step};
  // RL3: one sixteenth step
  // RL5: clamp at upper bound
  wire [15:0] up_val = (up_sum > {1'b0, act_q.shutter_max}) ? act_q.shutter_max
                     : up_sum[15:0];
  wire [15:0] dn_val = (step == 16'h0) ? shutter_q : shutter_q - step;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      shutter_q <= osfc_pkg::SHUTTER_RST;
    else if (ce)
    begin
      // RL4: manual exposure equals bound
      // RL22: held while auto gain off
      if (auto_gain_off)
        shutter_q <= act_q.shutter_max;
      // RL2: evaluated once per frame
      else if (frame_end && tracking_on)
      begin
        if (shutter_q > act_q.shutter_max)
          shutter_q <= act_q.shutter_max;
        else if (too_bright)
          shutter_q <= dn_val;
        else if (too_dark)
          shutter_q <= up_val;
      end
    end
  end

  // ----------------------------------------
  // Program RAM: capture, download, CRC
  // ----------------------------------------
  logic [7:0] ram [osfc_pkg::PIXEL_COUNT];
  osfc_pkg::osfc_ram_t ram_q;
  logic [PA-1:0] wptr_q;
  logic [PA-1:0] rptr_q;
  logic [15:0] crc_q;
  logic [15:0] data_out_q;
  logic [WA-1:0] wait_q;
  logic [1:0] pram_q;
  logic fifo_valid;
  logic [7:0] fifo_data;

  // Byte-wide CRC-16 (poly 0x1021), used by the self test
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {d, 8'h00};
    for (int i = 0; i < 8; i++)
      r = r[15] ? {r[14:0], 1'b0} ^ 16'h1021 : {r[14:0], 1'b0};
    crc_step = r;
  endfunction : crc_step

  wire cap_wr = wr_strobe & hit(acc_addr, osfc_pkg::ADDR_SNAPSHOT);
  wire cmd_wr = wr_strobe & hit(acc_addr, osfc_pkg::ADDR_PRAM_CMD);
  wire fill_wr = wr_strobe & hit(acc_addr, osfc_pkg::ADDR_PRAM_FILL) & (pram_q == 2'h2);
  wire capturing = ram_q == osfc_pkg::OSFC_RAM_CAPTURE;
  wire cap_take = capturing & fifo_valid;
  wire ram_we = cap_take | fill_wr;
  wire [7:0] ram_wd = cap_take ? fifo_data : wr_data;

  // The array drains only while capturing, so the FIFO fills and stalls it
  osfc_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .in_valid(pix_valid),
    .in_ready(pix_ready),
    .in_data(pix_data),
    .out_valid(fifo_valid),
    .out_ready(capturing),
    .out_data(fifo_data)
  );

  always_ff @(posedge clk)
  begin
    if (ce && ram_we)
      ram[wptr_q] <= ram_wd;
  end

  // Sequencer for the shared RAM
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ram_q <= osfc_pkg::OSFC_RAM_IDLE;
      halted_q <= 1'b0;
      wptr_q <= '0;
      rptr_q <= '0;
      crc_q <= osfc_pkg::CRC_SEED;
      data_out_q <= 16'h0;
      wait_q <= '0;
      pram_q <= 2'h0;
    end
    else if (ce)
    begin
      // RL12: any capture write halts tracking until reset
      if (cap_wr)
      begin
        halted_q <= 1'b1;
        pram_q <= 2'h0;
      end
      // RL17: arm then open the download path
      if (cmd_wr && wr_data == osfc_pkg::PRAM_ARM)
        pram_q <= 2'h1;
      else if (cmd_wr && wr_data == osfc_pkg::PRAM_OPEN && pram_q == 2'h1)
      begin
        pram_q <= 2'h2;
        wptr_q <= '0;
      end
      if (fill_wr)
        wptr_q <= (wptr_q == PIX_LAST) ? '0 : wptr_q + 1'b1;
      // RL13: read advances pointer
      // RL14: one pointer for both read paths
      if (pix_rd && ram_q == osfc_pkg::OSFC_RAM_READY)
        rptr_q <= (rptr_q == PIX_LAST) ? '0 : rptr_q + 1'b1;
      case (ram_q)
        osfc_pkg::OSFC_RAM_IDLE,
        osfc_pkg::OSFC_RAM_READY:
        begin
          // RL11: capture start code
          if (cap_wr && wr_data == osfc_pkg::SNAPSHOT_GO)
          begin
            ram_q <= osfc_pkg::OSFC_RAM_CAPTURE;
            wptr_q <= '0;
            rptr_q <= '0;
          end
          // RL18: CRC start code
          else if (cmd_wr && wr_data == osfc_pkg::PRAM_CRC)
          begin
            ram_q <= osfc_pkg::OSFC_RAM_CRC;
            rptr_q <= '0;
            crc_q <= osfc_pkg::CRC_SEED;
            wait_q <= '0;
          end
        end
        osfc_pkg::OSFC_RAM_CAPTURE:
        begin
          if (cap_take)
          begin
            wptr_q <= (wptr_q == PIX_LAST) ? '0 : wptr_q + 1'b1;
            if (wptr_q == PIX_LAST)
              ram_q <= osfc_pkg::OSFC_RAM_READY;
          end
        end
        osfc_pkg::OSFC_RAM_CRC:
        begin
          crc_q <= crc_step(crc_q, ram[rptr_q]);
          wait_q <= wait_q + 1'b1;
          rptr_q <= (rptr_q == PIX_LAST) ? '0 : rptr_q + 1'b1;
          if (rptr_q == PIX_LAST)
            ram_q <= osfc_pkg::OSFC_RAM_CRC_WAIT;
        end
        osfc_pkg::OSFC_RAM_CRC_WAIT:
        begin
          // Result posted only after the full wait plus one frame edge
          if (wait_q < WA'(CRC_WAIT))
            wait_q <= wait_q + 1'b1;
          else if (frame_end)
          begin
            data_out_q <= crc_q;
            ram_q <= osfc_pkg::OSFC_RAM_IDLE;
          end
        end
        default: ram_q <= osfc_pkg::OSFC_RAM_IDLE;
      endcase
    end
  end
  // RL19: tracking suspended during CRC
  assign tracking_on = ~halted_q & (ram_q != osfc_pkg::OSFC_RAM_CRC)
                     & (ram_q != osfc_pkg::OSFC_RAM_CRC_WAIT);

  // ----------------------------------------
  // Read mux and low-byte latches
  // ----------------------------------------
  logic [7:0] frame_lo_q;
  logic [7:0] shut_lo_q;
  // RL25: high read latches low byte
  // RL1: exposure pair coherence
  // RL7: frame period pair coherence
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      frame_lo_q <= 8'h0;
      shut_lo_q <= osfc_pkg::SHUTTER_RST[7:0];
    end
    else if (ce && rd_strobe)
    begin
      if (hit(acc_addr, osfc_pkg::ADDR_FRAME_LEN_HI))
        frame_lo_q <= period_q[7:0];
      if (hit(acc_addr, osfc_pkg::ADDR_SHUTTER_HI))
        shut_lo_q <= shutter_q[7:0];
    end
  end
  // RL15: zero before ready
  // RL16: written byte is never read back
  wire [7:0] pix_out = (ram_q == osfc_pkg::OSFC_RAM_READY) ? ram[rptr_q] : 8'h00;
  always_comb
  begin
    case (acc_addr)
      osfc_pkg::ADDR_DATA_OUT_LO: rd_data = data_out_q[7:0];
      osfc_pkg::ADDR_DATA_OUT_HI: rd_data = data_out_q[15:8];
      osfc_pkg::ADDR_SHUTTER_LO: rd_data = shut_lo_q;
      osfc_pkg::ADDR_SHUTTER_HI: rd_data = shutter_q[15:8];
      osfc_pkg::ADDR_FRAME_LEN_LO: rd_data = frame_lo_q;
      osfc_pkg::ADDR_FRAME_LEN_HI: rd_data = period_q[15:8];
      osfc_pkg::ADDR_SNAPSHOT: rd_data = pix_out;
      osfc_pkg::ADDR_PIXEL_BURST: rd_data = pix_out;
      osfc_pkg::ADDR_SEC_CONFIG: rd_data = cfg_q;
      default: rd_data = 8'h00;
    endcase
  end
endmodule : osfc_regs

// file: tb/osfc_checker.sv
// Port-level assertions for the frame control register block
module osfc_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Serial port
  input wire logic ncs_n,
  input wire logic miso_oe,
  // Bounds
  input wire logic locked_frame_rate,
  input wire osfc_pkg::osfc_bounds_t bounds,
  input wire logic bounds_load,
  input wire logic bounds_busy,
  // Status outputs
  input wire logic frame_start,
  input wire logic tracking_on,
  input wire logic motion_zero,
  input wire logic laser_enable_n
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // ----------------------------------------
  // Helper counters
  // ----------------------------------------
  logic [15:0] len_q;
  logic [7:0] fs_q;
  logic settled_q;
  logic armed_q;
  // Frame length and frames since load; settled one frame after busy drops, once loaded
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n) len_q <= 16'h0000;
    else len_q <= frame_start ? 16'h0000 : len_q + 16'h0001;
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n) fs_q <= 8'h00;
    else fs_q <= bounds_load ? 8'h00 : fs_q + {7'h00, frame_start};
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n) armed_q <= 1'b0;
    else if (bounds_load) armed_q <= 1'b1;
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n) settled_q <= 1'b0;
    else if (bounds_load) settled_q <= 1'b0;
    else if (frame_start && !bounds_busy && armed_q) settled_q <= 1'b1;
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  chk_zero_pulse: assert property (motion_zero |=> !motion_zero)
    else $error("motion clear pulse too long");
  chk_laser_halt: assert property (!tracking_on |-> laser_enable_n)
    else $error("laser on while tracking halted");
  chk_track_stays: assert property ($rose(tracking_on) |-> $past(frame_start))
    else $error("tracking resumed off a frame edge");
  chk_laser_cause: assert property (tracking_on && $changed(laser_enable_n) |-> !$past(ncs_n, 4))
    else $error("laser enable moved without a port write");
  chk_busy_rise: assert property (bounds_load |=> bounds_busy)
    else $error("busy not raised by load");
  chk_busy_two: assert property ($fell(bounds_busy) |-> fs_q >= 8'h02 && fs_q <= 8'h03)
    else $error("busy dropped before two frames");
  chk_frame_exact: assert property (frame_start && settled_q && locked_frame_rate
    |-> len_q == bounds.frame_max - 16'h0001)
    else $error("locked frame length wrong");
  chk_oe_quiet: assert property (ncs_n [*4] |-> !miso_oe)
    else $error("data out driven while deselected");
  // Main scenarios reached
  cover property ($rose(motion_zero));
  cover property ($fell(bounds_busy));
  cover property ($fell(tracking_on));
endmodule : osfc_checker

// file: tb/osfc_host.sv
// Host-side serial port model driving the register block's pins
module osfc_host (
  // Clock
  input wire logic clk,
  // Serial pins
  output logic sclk,
  output logic mosi,
  output logic ncs_n,
  input wire logic miso
);
  timeunit 1ns;
  timeprecision 1ps;
  // Half period of 5 clocks keeps the serial clock below clk/8
  localparam int HALF = 5;
  initial
  begin
    sclk = 1'b1;
    mosi = 1'b0;
    ncs_n = 1'b1;
  end
  // ----------------------------------------
  // One framed transaction
  // ----------------------------------------
  // one access per select
  task automatic xfer(input logic [7:0] hdr, input logic [7:0] wd, output logic [7:0] rd);
    logic [15:0] sh;
    sh = {hdr, wd};
    rd = 8'h00;
    @(posedge clk);
    ncs_n <= 1'b0;
    for (int i = 15; i >= 0; i--)
    begin
      repeat (HALF) @(posedge clk);
      sclk <= 1'b0;
      // Unused data line toggles so the device never sees a stale level
      mosi <= (i < 8 && !hdr[7]) ? ~mosi : sh[i];
      repeat (HALF) @(posedge clk);
      sclk <= 1'b1;
      if (i < 8)
        rd[i] = miso;
    end
    repeat (HALF) @(posedge clk);
    ncs_n <= 1'b1;
    repeat (4 * HALF) @(posedge clk);
  endtask : xfer
endmodule : osfc_host

// file: tb/osfc_regs_tb.sv
// Self-checking bench for the frame control register block
module osfc_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic sclk, mosi, ncs_n, miso, miso_oe;
  logic auto_gain_off = 1'b0;
  logic locked_frame_rate = 1'b0;
  osfc_pkg::osfc_bounds_t bounds = 48'h0;
  logic bounds_load = 1'b0;
  logic bounds_busy, pix_ready, frame_start, tracking_on, motion_zero, laser_enable_n;
  logic [7:0] pix_data = 8'h00;
  logic [7:0] pix_avg = 8'h80;
  logic [7:0] mz_cnt = 8'h00;
  int fails = 0;
  int n_tests = 0;
  int cyc = 0;
  initial
  begin
    forever #25 clk = ~clk;
  end
  osfc_regs #(.CRC_WAIT(50)) dut (
    .clk(clk), .rst_n(rst_n), .ce(1'b1), .sclk(sclk), .mosi(mosi), .ncs_n(ncs_n),
    .miso(miso), .miso_oe(miso_oe), .auto_gain_off(auto_gain_off),
    .locked_frame_rate(locked_frame_rate), .bounds(bounds), .bounds_load(bounds_load),
    .bounds_busy(bounds_busy), .pix_avg(pix_avg), .pix_max(8'h90), .pix_valid(1'b1),
    .pix_ready(pix_ready), .pix_data(pix_data), .frame_start(frame_start),
    .tracking_on(tracking_on), .motion_zero(motion_zero), .laser_enable_n(laser_enable_n)
  );
  osfc_host host (.clk(clk), .sclk(sclk), .mosi(mosi), .ncs_n(ncs_n), .miso(miso));
  // Pixel byte k carries k, so captured data is predictable; count clear pulses
  always @(posedge clk)
  begin
    if (rst_n && pix_ready === 1'b1) pix_data <= pix_data + 8'h01;
    if (motion_zero === 1'b1) mz_cnt <= mz_cnt + 8'h01;
  end
  // Hang guard, about three times the expected run
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      fails++;
      close_out();
    end
  end
  // ----------------------------------------
  // Compare and access tasks
  // ----------------------------------------
  task automatic cmp8(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e)
    begin
      fails++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp8
  task automatic cmp1(input string nm, input logic e, input logic g);
    n_tests++;
    if (g !== e)
    begin
      fails++;
      $display("FAIL %s expected %b seen %b", nm, e, g);
    end
  endtask : cmp1
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    logic [7:0] q;
    host.xfer({1'b0, a}, 8'h00, q);
    cmp8($sformatf("addr %h", a), e, q);
  endtask : rd
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] q;
    host.xfer({1'b1, a}, d, q);
  endtask : wr
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : close_out
  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial
  begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd(osfc_pkg::ADDR_SEC_CONFIG, osfc_pkg::SEC_CONFIG_RST);
    cmp1("laser_enable_n", 1'b0, laser_enable_n);
    wr(osfc_pkg::ADDR_SEC_CONFIG, 8'h36);
    cmp1("laser_enable_n", 1'b1, laser_enable_n);
    rd(osfc_pkg::ADDR_SEC_CONFIG, 8'h36);
    wr(osfc_pkg::ADDR_SEC_CONFIG, osfc_pkg::SEC_CONFIG_RST);
    cmp1("laser_enable_n", 1'b0, laser_enable_n);
    rd(7'h15, 8'h00);
    $display("test config done");
    wr(osfc_pkg::ADDR_MOVE_ZERO, 8'ha5);
    cmp8("motion_zero pulses", 8'h01, mz_cnt);
    cmp1("tracking_on", 1'b1, tracking_on);
    $display("test motion done");
    auto_gain_off <= 1'b1;
    locked_frame_rate <= 1'b1;
    bounds <= {16'h0040, 16'h0020, 16'h0010};
    bounds_load <= 1'b1;
    @(posedge clk);
    bounds_load <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 1000 && bounds_busy !== 1'b0; i++)
      @(posedge clk);
    cmp1("bounds_busy", 1'b0, bounds_busy);
    repeat (300) @(posedge clk);
    rd(osfc_pkg::ADDR_FRAME_LEN_HI, 8'h00);
    rd(osfc_pkg::ADDR_FRAME_LEN_LO, 8'h40);
    rd(osfc_pkg::ADDR_SHUTTER_HI, 8'h00);
    rd(osfc_pkg::ADDR_SHUTTER_LO, 8'h10);
    auto_gain_off <= 1'b0;
    pix_avg <= 8'hf0;
    repeat (64) @(posedge clk);
    pix_avg <= 8'h80;
    rd(osfc_pkg::ADDR_SHUTTER_HI, 8'h00);
    rd(osfc_pkg::ADDR_SHUTTER_LO, 8'h0f);
    wr(osfc_pkg::ADDR_PRAM_CMD, osfc_pkg::PRAM_ARM);
    wr(osfc_pkg::ADDR_PRAM_CMD, osfc_pkg::PRAM_OPEN);
    $display("test bounds done");
    rd(osfc_pkg::ADDR_SNAPSHOT, 8'h00);
    wr(osfc_pkg::ADDR_SNAPSHOT, osfc_pkg::SNAPSHOT_GO);
    cmp1("tracking_on", 1'b0, tracking_on);
    cmp1("laser_enable_n", 1'b1, laser_enable_n);
    repeat (2000) @(posedge clk);
    for (int i = 0; i < 4; i++)
      rd(osfc_pkg::ADDR_SNAPSHOT, 8'(i));
    rd(osfc_pkg::ADDR_PIXEL_BURST, 8'h04);
    $display("test capture done");
    close_out();
  end
endmodule : osfc_regs_tb
bind osfc_regs osfc_checker chk (
  .clk(clk), .rst_n(rst_n), .ncs_n(ncs_n), .miso_oe(miso_oe),
  .locked_frame_rate(locked_frame_rate), .bounds(bounds), .bounds_load(bounds_load),
  .bounds_busy(bounds_busy), .frame_start(frame_start), .tracking_on(tracking_on),
  .motion_zero(motion_zero), .laser_enable_n(laser_enable_n)
);
